// ### design/sipo_pkg.sv
// Package for the latched serial-in parallel-out shifter
package sipo_pkg;

  // ==========================================================
  // Sizes and reset values
  localparam int SIPO_STAGES = 8;
  localparam logic [SIPO_STAGES-1:0] SIPO_CHAIN_RST = 8'h00;
  localparam logic [SIPO_STAGES-1:0] SIPO_CLEARED = 8'h00;
  localparam logic SIPO_PIN_RST = 1'b0;
  localparam logic SIPO_OE_N_RST = 1'b1;

  // ==========================================================
  // Pin groups
  typedef struct packed {
    logic serial_in;
    logic shift_clock;
    logic shift_clear_n;
    logic store_clock;
    logic output_enable_n;
  } sipo_pins_in_t;

  typedef struct packed {
    logic [SIPO_STAGES-1:0] parallel_out;
    logic [SIPO_STAGES-1:0] parallel_oe_n;
    logic cascade_out;
  } sipo_pins_out_t;

endpackage

// ### design/sipo_rise_detect.sv
// Rising edge detector for a pin sampled on clk
`timescale 1ns/1ns
module sipo_rise_detect (
  input wire logic clk,
  input wire logic rst,
  input wire logic pin,
  output logic rise
);
  import sipo_pkg::*;

  logic prev_q;
  logic prev_d;

  // ==========================================================
  // Previous level
  always_comb begin
    prev_d = pin;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= SIPO_PIN_RST;
    end else begin
      prev_q <= prev_d;
    end
  end

  // Falling edges give no pulse
  assign rise = pin & ~prev_q;

endmodule // sipo_rise_detect

// ### design/sipo_latched_shifter.sv
// Eight-stage shift chain with a storage register and gated outputs
// Contract
// [RL1] Eight-stage chain feeds eight-bit storage register
// [RL2] Storage bits drive the gated parallel outputs
// [RL3] Separate clocks, each touching only its register
// [RL4] Low clear empties chain, storage untouched
// [RL5] Cascade output carries last chain stage
// [RL6] Enable high floats outputs, cascade stays driven
// [RL7] Only rising clock edges or a low clear change state
// [RL8] Shift edge loads serial in, stages advance
// [RL9] Store edge copies whole chain to storage
// [RL10] Shared clock: storage takes pre-shift chain
// [RL11] Host sets data, clear high, before edge
// [RL12] Cleared chain is all low, cascade low
// [RL13] Storage has no reset, store edges only
`timescale 1ns/1ns
module sipo_latched_shifter (
  input wire logic clk,
  input wire logic rst,
  input sipo_pkg::sipo_pins_in_t pins_in,
  output sipo_pkg::sipo_pins_out_t pins_out
);
  import sipo_pkg::*;

  logic shift_rise;
  logic store_rise;
  logic [SIPO_STAGES-1:0] chain_q;
  logic [SIPO_STAGES-1:0] chain_d;
  logic [SIPO_STAGES-1:0] store_q;
  logic [SIPO_STAGES-1:0] store_d;
  logic oe_n_q;
  logic oe_n_d;
  logic store_seen_q;
  logic store_seen_d;

  // ==========================================================
  // Clock edge detection
  sipo_rise_detect u_shift_edge (
    .clk(clk),
    .rst(rst),
    .pin(pins_in.shift_clock),
    .rise(shift_rise)
  );

  sipo_rise_detect u_store_edge (
    .clk(clk),
    .rst(rst),
    .pin(pins_in.store_clock),
    .rise(store_rise)
  );

  // ==========================================================
  // Shift chain
  always_comb begin
    chain_d = chain_q;
    if (!pins_in.shift_clear_n) begin
      chain_d = SIPO_CLEARED; // see [RL4] see [RL12]
    end else if (shift_rise) begin
      // Host keeps serial_in steady up to the edge; see [RL11]
      chain_d = {chain_q[SIPO_STAGES-2:0], pins_in.serial_in}; // see [RL8] see [RL7]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      chain_q <= SIPO_CHAIN_RST;
    end else begin
      chain_q <= chain_d; // see [RL1] see [RL3]
    end
  end

  // ==========================================================
  // Storage register
  always_comb begin
    store_d = store_q;
    if (store_rise) begin
      // Old chain value, so a shared clock lags by one; see [RL10]
      store_d = chain_q; // see [RL9] see [RL3]
    end
  end

  // No reset here: contents are unknown until the first store edge
  always_ff @(posedge clk) begin
    store_q <= store_d; // see [RL13]
  end

  // ==========================================================
  // Storage known flag
  // Checks only, so unknown storage before the first store edge is not judged
  always_comb begin
    store_seen_d = store_seen_q;
    if (store_rise) begin
      store_seen_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      store_seen_q <= 1'b0;
    end else begin
      store_seen_q <= store_seen_d;
    end
  end

  // ==========================================================
  // Output enable
  always_comb begin
    oe_n_d = pins_in.output_enable_n;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      oe_n_q <= SIPO_OE_N_RST;
    end else begin
      oe_n_q <= oe_n_d;
    end
  end

  assign pins_out.parallel_out = store_q; // see [RL2]
  assign pins_out.parallel_oe_n = {SIPO_STAGES{oe_n_q}}; // see [RL6]
  assign pins_out.cascade_out = chain_q[SIPO_STAGES-1]; // see [RL5]

  // ==========================================================
  // Checks
  AST_CLEAR_EMPTIES: assert property (@(posedge clk) disable iff (rst) // see [RL4]
    !pins_in.shift_clear_n |=> (chain_q == SIPO_CLEARED))
    else $error("chain not cleared after clear");

  AST_CLEAR_CASCADE_LOW: assert property (@(posedge clk) disable iff (rst) // see [RL12]
    !pins_in.shift_clear_n |=> !pins_out.cascade_out)
    else $error("cascade not low after clear");

  AST_CLEAR_KEEPS_STORE: assert property (@(posedge clk) disable iff (rst) // see [RL4]
    (!pins_in.shift_clear_n && !store_rise && store_seen_q)
    |=> $stable(pins_out.parallel_out))
    else $error("clear disturbed storage");

  AST_SHIFT_STEP: assert property (@(posedge clk) disable iff (rst) // see [RL8]
    (pins_in.shift_clock && !$past(pins_in.shift_clock) && pins_in.shift_clear_n)
    |=> (chain_q == {$past(chain_q[SIPO_STAGES-2:0]), $past(pins_in.serial_in)}))
    else $error("shift edge did not advance chain");

  AST_SHIFT_HOLD: assert property (@(posedge clk) disable iff (rst) // see [RL7]
    (!shift_rise && pins_in.shift_clear_n) |=> $stable(chain_q))
    else $error("chain moved without rising shift edge");

  AST_STORE_COPY: assert property (@(posedge clk) disable iff (rst) // see [RL10]
    store_rise |=> (pins_out.parallel_out == $past(chain_q)))
    else $error("storage did not take pre-edge chain");

  AST_STORE_HOLD: assert property (@(posedge clk) disable iff (rst) // see [RL13]
    (!store_rise && store_seen_q) |=> $stable(pins_out.parallel_out))
    else $error("storage changed without store edge");

  AST_OE_FOLLOWS: assert property (@(posedge clk) disable iff (rst) // see [RL6]
    pins_in.output_enable_n |=> (pins_out.parallel_oe_n == {SIPO_STAGES{1'b1}}))
    else $error("outputs not floated when enable high");

  AST_CASCADE_DELAY: assert property (@(posedge clk) disable iff (rst) // see [RL5]
    (shift_rise && pins_in.shift_clear_n)
    |=> (pins_out.cascade_out == $past(chain_q[SIPO_STAGES-2])))
    else $error("cascade not last stage");

  // ==========================================================
  // Further checks
  AST_CLEAR_WINS: assert property (@(posedge clk) disable iff (rst) // see [RL4]
    (!pins_in.shift_clear_n && shift_rise)
    |=> (chain_q == SIPO_CLEARED))
    else $error("shift edge beat clear");

  AST_FALL_IGNORED: assert property (@(posedge clk) disable iff (rst) // see [RL7]
    (!pins_in.shift_clock && $past(pins_in.shift_clock) && pins_in.shift_clear_n)
    |=> $stable(chain_q))
    else $error("falling shift edge moved chain");

  AST_FIRST_STAGE: assert property (@(posedge clk) disable iff (rst) // see [RL8]
    (shift_rise && pins_in.shift_clear_n)
    |=> (chain_q[0] == $past(pins_in.serial_in)))
    else $error("first stage missed serial input");

  AST_OE_DRIVES: assert property (@(posedge clk) disable iff (rst) // see [RL6]
    !pins_in.output_enable_n
    |=> (pins_out.parallel_oe_n == {SIPO_STAGES{1'b0}}))
    else $error("outputs not driven when enable low");

  AST_CASCADE_WHILE_FLOAT: assert property (@(posedge clk) disable iff (rst) // see [RL6]
    (pins_in.output_enable_n && shift_rise && pins_in.shift_clear_n)
    |=> (pins_out.cascade_out == $past(chain_q[SIPO_STAGES-2])))
    else $error("cascade stalled while outputs float");

  AST_SHIFT_KEEPS_STORE: assert property (@(posedge clk) disable iff (rst) // see [RL3]
    (shift_rise && !store_rise && store_seen_q)
    |=> $stable(pins_out.parallel_out))
    else $error("shift edge disturbed storage");

  AST_STORE_KEEPS_CHAIN: assert property (@(posedge clk) disable iff (rst) // see [RL3]
    (store_rise && !shift_rise && pins_in.shift_clear_n)
    |=> $stable(chain_q))
    else $error("store edge disturbed chain");

  AST_CHAIN_WIDTH: assert property (@(posedge clk) disable iff (rst) // see [RL1]
    (shift_rise && pins_in.shift_clear_n)
    |=> (chain_q[SIPO_STAGES-1:1] == $past(chain_q[SIPO_STAGES-2:0])))
    else $error("chain stages did not advance");

  AST_STORE_DRIVES_PINS: assert property (@(posedge clk) disable iff (rst) // see [RL2]
    (store_rise && !pins_in.output_enable_n)
    |=> (pins_out.parallel_out == $past(chain_q)
         && pins_out.parallel_oe_n == {SIPO_STAGES{1'b0}}))
    else $error("stored bits not driven on outputs");

  AST_CLEAR_HOLDS: assert property (@(posedge clk) disable iff (rst) // see [RL12]
    (!pins_in.shift_clear_n && !$past(pins_in.shift_clear_n))
    |=> (chain_q == SIPO_CLEARED))
    else $error("chain left clear while clear held");

  COV_SHIFT: cover property (@(posedge clk) disable iff (rst)
    shift_rise && pins_in.shift_clear_n);
  COV_STORE: cover property (@(posedge clk) disable iff (rst) store_rise);
  COV_SHARED: cover property (@(posedge clk) disable iff (rst)
    shift_rise && store_rise && pins_in.shift_clear_n);
  COV_CLEAR: cover property (@(posedge clk) disable iff (rst)
    !pins_in.shift_clear_n && shift_rise);
  COV_FLOAT: cover property (@(posedge clk) disable iff (rst)
    pins_in.output_enable_n && store_rise);

endmodule // sipo_latched_shifter

// ### sim/sipo_host.sv
// Host model that drives the shifter pins
`timescale 1ns/1ns
module sipo_host (
  input wire logic clk,
  output sipo_pkg::sipo_pins_in_t p
);
  import sipo_pkg::*;
  // ====================
  // Pin sequences
  initial p = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  task automatic pulse(input logic sh, input logic b, input logic st);
    @(negedge clk);
    p.shift_clock = 1'b0;
    p.store_clock = 1'b0;
    // Stale data is not held past its edge
    p.serial_in = ~p.serial_in;
    @(negedge clk);
    p.serial_in = b;
    p.shift_clock = sh;
    p.store_clock = st;
  endtask
  task automatic clear;
    @(negedge clk);
    p.shift_clear_n = 1'b0;
    @(negedge clk);
    p.shift_clear_n = 1'b1;
  endtask
  task automatic oe(input logic v);
    @(negedge clk);
    p.output_enable_n = v;
  endtask
endmodule // sipo_host

// ### sim/testbench.sv
// Self-checking bench for the latched shifter
`timescale 1ns/1ns
module testbench;
  import sipo_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  sipo_pins_in_t pins_in;
  sipo_pins_out_t pins_out;
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  // ====================
  // Harness
  always #5 clk = ~clk;
  sipo_host host (.clk(clk), .p(pins_in));
  sipo_latched_shifter uut (.clk(clk), .rst(rst), .pins_in(pins_in), .pins_out(pins_out));
  task automatic stop_test;
    if (miscompares == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Run needs about 90 cycles, so this leaves ample margin
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      miscompares++;
      stop_test();
    end
  end
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic settle;
    repeat (2) @(negedge clk);
  endtask
  task automatic shift_byte(input logic [7:0] v, input logic st);
    for (int i = 7; i >= 0; i--) begin
      host.pulse(1'b1, v[i], st);
    end
    settle();
  endtask
  // ====================
  // Scenarios
  task automatic t_shift_store;
    host.oe(1'b0);
    shift_byte(8'hA5, 1'b0);
    check("cascade", 8'h01, {7'h00, pins_out.cascade_out});
    host.pulse(1'b0, 1'b0, 1'b1);
    settle();
    check("parallel", 8'hA5, pins_out.parallel_out);
    check("oe_n", 8'h00, pins_out.parallel_oe_n);
  endtask
  task automatic t_shared;
    shift_byte(8'hC3, 1'b1);
    check("lagged", 8'hE1, pins_out.parallel_out);
  endtask
  task automatic t_reset;
    // Clocks low first, or release would see a false rising edge
    host.pulse(1'b0, 1'b0, 1'b0);
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    settle();
    check("reset cascade", 8'h00, {7'h00, pins_out.cascade_out});
    check("reset kept", 8'hE1, pins_out.parallel_out);
    shift_byte(8'hFF, 1'b0);
    check("refill cascade", 8'h01, {7'h00, pins_out.cascade_out});
    check("shift kept", 8'hE1, pins_out.parallel_out);
  endtask
  task automatic t_clear;
    host.clear();
    host.oe(1'b1);
    settle();
    check("kept", 8'hE1, pins_out.parallel_out);
    check("cascade", 8'h00, {7'h00, pins_out.cascade_out});
    check("oe_n", 8'hFF, pins_out.parallel_oe_n);
    host.pulse(1'b0, 1'b0, 1'b1);
    settle();
    check("emptied", 8'h00, pins_out.parallel_out);
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_shift_store();
    t_shared();
    t_reset();
    t_clear();
    stop_test();
  end
endmodule // testbench
